// [hdl/hmfe_pkg.sv]
// Constants shared by the request/response frame engine
package hmfe_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_HZ       = 100_000_000;
  localparam int BAUD_BPS     = 1200;
  localparam int BIT_CYC      = CLK_HZ / BAUD_BPS;
  localparam int RESP_TMO_MS  = 300;
  localparam int RESP_CYC     = RESP_TMO_MS * (CLK_HZ / 1000);
  localparam int GAP_BITS     = 22;
  localparam int GAP_CYC      = GAP_BITS * BIT_CYC;
  localparam int CHAR_BITS    = 11;
  localparam int FIFO_DEPTH   = 4;

  // ==========================================================
  // Frame fields
  localparam logic [7:0] PRE_BYTE   = 8'hFF;
  localparam logic [7:0] PRE_MIN    = 8'h05;
  localparam logic [7:0] PRE_MAX    = 8'h14;
  localparam logic [7:0] DLM_BST_S  = 8'h01;
  localparam logic [7:0] DLM_STX_S  = 8'h02;
  localparam logic [7:0] DLM_ACK_S  = 8'h06;
  localparam logic [7:0] DLM_BST_L  = 8'h81;
  localparam logic [7:0] DLM_STX_L  = 8'h82;
  localparam logic [7:0] DLM_ACK_L  = 8'h86;
  localparam int         DLM_LONG_BIT   = 7;
  localparam int         ADR_MASTER_BIT = 7;
  localparam int         ADR_BURST_BIT  = 6;
  localparam logic [7:0] ADR_LAST_S = 8'h00;
  localparam logic [7:0] ADR_LAST_L = 8'h04;
  localparam logic [39:0] ADR_MASK_S = 40'h00_0000_003F;
  localparam logic [39:0] ADR_MASK_L = 40'hFF_FFFF_FF3F;
  localparam logic [7:0] RC_BYTES   = 8'h02;
  localparam logic [3:0] CHAN_MAX   = 4'h7;

  // ==========================================================
  // Bus state codes (two's complement)
  localparam logic [7:0] BS_IDLE    = 8'h00;
  localparam logic [7:0] BS_QUEUED  = 8'h01;
  localparam logic [7:0] BS_SENT    = 8'h02;
  localparam logic [7:0] BS_WAIT    = 8'h03;
  localparam logic [7:0] BS_RECV    = 8'h04;
  localparam logic [7:0] BS_TMO     = 8'hFF;
  localparam logic [7:0] BS_SHORT   = 8'hFE;
  localparam logic [7:0] BS_DLM     = 8'hFD;
  localparam logic [7:0] BS_MASTER  = 8'hFC;
  localparam logic [7:0] BS_BURST   = 8'hFB;
  localparam logic [7:0] BS_CMD     = 8'hFA;
  localparam logic [7:0] BS_CHK     = 8'hF9;
  localparam logic [7:0] BS_RESP    = 8'hF8;
  localparam logic [7:0] BS_MISM    = 8'h9E;
  localparam logic [7:0] BS_IMPOSS  = 8'h9D;
  localparam logic [7:0] BS_TXFAIL  = 8'h9C;
  localparam logic [7:0] BS_NOMOD   = 8'h9B;
  localparam logic [7:0] BS_OFFL    = 8'h9A;

  // ==========================================================
  // Send and read answer codes
  localparam logic [7:0] RS_OK      = 8'h01;
  localparam logic [7:0] RS_NOMOD   = 8'hFF;
  localparam logic [7:0] RS_CHAN    = 8'hFE;
  localparam logic [7:0] RS_PRE     = 8'hFD;
  localparam logic [7:0] RS_FRAME   = 8'hFC;
  localparam logic [7:0] RS_BUSY    = 8'hFB;
  localparam logic [7:0] RS_OFFL_S  = 8'hFA;
  localparam logic [7:0] RD_INVAL   = 8'hFE;
  localparam logic [7:0] RD_WAIT    = 8'hFD;
  localparam logic [7:0] RD_NOREQ   = 8'hFC;
  localparam logic [7:0] RD_OFFL    = 8'hFB;

endpackage

// [hdl/hmfe_fifo.sv]
// Small first-in first-out buffer with valid/ready on both sides
`timescale 1ns/100ps
module hmfe_fifo
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
)
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             push_w;
  logic             pop_w;
  logic [AW:0]      cnt_nxt;

  // ==========================================================
  // Pointer wrap
  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  // Handshake decode
  assign cnt_nxt   = cnt_r + (AW+1)'(push_w) - (AW+1)'(pop_w);
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rp_r];
  assign push_w    = in_valid && in_ready;
  assign pop_w     = out_valid && out_ready;

  // Storage
  always_ff @(posedge clk)
  begin
    if (push_w)
      mem[wp_r] <= in_data;
  end

  // Pointers and fill level
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
      in_ready <= 1'b0;
    end
    else
    begin
      if (push_w)
        wp_r <= wrap_inc(wp_r);
      if (pop_w)
        rp_r <= wrap_inc(rp_r);
      cnt_r <= cnt_nxt;
      in_ready <= (cnt_nxt != FULL_CNT); // Registered ready
    end
  end
endmodule

// [hdl/hmfe_uart.sv]
// Character transmitter and receiver, 8 data bits, odd parity
`timescale 1ns/100ps
module hmfe_uart
  import hmfe_pkg::*;
#(
  parameter int BIT_CYCLES = hmfe_pkg::BIT_CYC
)
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       tx_start,
  input  wire logic [7:0] tx_byte,
  output logic            tx_busy,
  output logic            tx_line,
  input  wire logic       rx_line,
  output logic            rx_valid,
  output logic      [7:0] rx_byte,
  output logic            rx_err
);
  localparam int CW = $clog2(BIT_CYCLES + 1);
  localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYCLES - 1);
  localparam logic [CW-1:0] BIT_HALF = CW'(BIT_CYCLES / 2);

  logic [CW-1:0] tcnt_r;
  logic [3:0]    tbit_r;
  logic [10:0]   tsh_r;
  logic [CW-1:0] rcnt_r;
  logic [3:0]    rbit_r;
  logic [9:0]    rsh_r;
  logic          rbusy_r;
  logic          rprev_r;
  logic          tend_w;
  logic          rtick_w;

  // ==========================================================
  // Transmit: start, data LSB first, odd parity, stop
  assign tend_w = (tcnt_r == BIT_LAST);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      tx_busy <= 1'b0;
      tx_line <= 1'b1;
      tcnt_r  <= '0;
      tbit_r  <= '0;
      tsh_r   <= '1;
    end
    else if (!tx_busy && tx_start)
    begin
      tx_busy <= 1'b1;
      tsh_r   <= {1'b1, ~^tx_byte, tx_byte, 1'b0};
      tx_line <= 1'b0;
      tcnt_r  <= '0;
      tbit_r  <= '0;
    end
    else if (tx_busy)
    begin
      tcnt_r <= tend_w ? '0 : tcnt_r + CW'(1);
      if (tend_w)
      begin
        tbit_r  <= tbit_r + 4'h1;
        tsh_r   <= {1'b1, tsh_r[10:1]};
        tx_line <= tsh_r[1];
        if (tbit_r == 4'(CHAR_BITS - 1))
        begin
          tx_busy <= 1'b0;
          tx_line <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Receive: mid-bit sampling after start edge
  assign rtick_w = rbusy_r &&
                   (rcnt_r == ((rbit_r == 4'h0) ? BIT_HALF : BIT_LAST));

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rprev_r  <= 1'b1;
      rbusy_r  <= 1'b0;
      rcnt_r   <= '0;
      rbit_r   <= '0;
      rsh_r    <= '0;
      rx_valid <= 1'b0;
      rx_byte  <= '0;
      rx_err   <= 1'b0;
    end
    else
    begin
      rprev_r  <= rx_line;
      rx_valid <= 1'b0;
      if (!rbusy_r)
      begin
        rcnt_r <= '0;
        rbit_r <= '0;
        if (rprev_r && !rx_line)
          rbusy_r <= 1'b1;
      end
      else if (rtick_w)
      begin
        rcnt_r <= '0;
        rbit_r <= rbit_r + 4'h1;
        if (rbit_r == 4'h0 && rx_line)
          rbusy_r <= 1'b0; // False start
        else if (rbit_r != 4'h0)
          rsh_r <= {rx_line, rsh_r[9:1]};
        if (rbit_r == 4'(CHAR_BITS - 1))
        begin
          rbusy_r  <= 1'b0;
          rx_valid <= 1'b1;
          rx_byte  <= rsh_r[8:1]; // Parity sits above the data
          rx_err   <= !rx_line || !(^rsh_r[9:1]);
        end
      end
      else
        rcnt_r <= rcnt_r + CW'(1);
    end
  end
endmodule

// [hdl/hmfe_engine.sv]
// Master frame engine: builds requests, checks responses
`timescale 1ns/100ps
module hmfe_engine
  import hmfe_pkg::*;
#(
  parameter int BIT_CYCLES  = hmfe_pkg::BIT_CYC,
  parameter int RESP_CYCLES = hmfe_pkg::RESP_CYC,
  parameter int GAP_CYCLES  = hmfe_pkg::GAP_CYC
)
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        module_present,
  input  wire logic        module_online,
  input  wire logic        line_fault,
  input  wire logic        send_req,
  input  wire logic [3:0]  loop_channel_index,
  input  wire logic [7:0]  preamble_count,
  input  wire logic [7:0]  frame_delimiter,
  input  wire logic [39:0] frame_address_bytes,
  input  wire logic [7:0]  frame_command,
  input  wire logic [7:0]  payload_length,
  input  wire logic        pay_valid,
  output logic             pay_ready,
  input  wire logic [7:0]  pay_data,
  output logic             send_done,
  output logic      [7:0]  send_status,
  input  wire logic        read_req,
  output logic             read_done,
  output logic      [7:0]  read_status,
  output logic      [7:0]  bus_state,
  output logic      [7:0]  resp_preamble_count,
  output logic      [7:0]  resp_delimiter,
  output logic      [39:0] resp_address_bytes,
  output logic      [7:0]  resp_command,
  output logic      [15:0] resp_code,
  output logic      [7:0]  resp_payload_length,
  output logic             rd_valid,
  output logic      [7:0]  rd_byte,
  output logic      [2:0]  chan_sel,
  output logic             tx_enable,
  output logic             tx_line,
  input  wire logic        rx_line
);
  typedef enum logic [4:0] {
    S_IDLE, S_PRE, S_DLM, S_ADDR, S_CMD, S_CNT, S_DATA, S_CHK,
    S_FLUSH, S_WAIT, S_RPRE, S_RADDR, S_RCMD, S_RCNT, S_RBODY, S_RCHK
  } hmfe_state_type;

  hmfe_state_type st_r;
  logic [7:0]  pre_r, dlm_r, cmd_r, len_r, idx_r, chk_r, txb_r;
  logic [39:0] addr_r;
  logic        tx_go_r;
  logic [31:0] tmr_r;
  logic [7:0]  rpre_r, rdlm_r, rcmd_r, rcnt_r, rchk_r;
  logic [39:0] raddr_r;
  logic [15:0] rc_r;
  logic        rerr_r;
  logic [7:0]  rd_idx_r, rd_left_r;
  logic [7:0]  mem [0:255];

  logic        tx_busy_w, rx_valid_w, rx_err_w;
  logic [7:0]  rx_byte_w, txb_w, alast_w, send_code_w, read_code_w;
  logic [7:0]  eval_w, nbus_w;
  logic        fifo_vld_w, fire_w, pop_w, long_w, tx_st_w, rx_st_w;
  logic        dlm_ok_w, gap_w, mem_we_w, busy_w, rd_go_w, accept_w;
  logic [39:0] amask_w;
  logic [7:0]  txb_w_fifo;

  // ==========================================================
  // Address byte i of a 40-bit field, byte 0 sent first
  function automatic logic [7:0] abyte(input logic [39:0] a,
                                       input logic [7:0]  i);
    abyte = a[{i[2:0], 3'b000} +: 8];
  endfunction

  // ==========================================================
  // Payload buffer and character port
  hmfe_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (pay_valid),
    .in_ready  (pay_ready),
    .in_data   (pay_data),
    .out_valid (fifo_vld_w),
    .out_ready (pop_w),
    .out_data  (txb_w_fifo)
  );

  hmfe_uart #(.BIT_CYCLES(BIT_CYCLES)) u_uart (
    .clk      (clk),
    .reset    (reset),
    .tx_start (tx_go_r),
    .tx_byte  (txb_r),
    .tx_busy  (tx_busy_w),
    .tx_line  (tx_line),
    .rx_line  (rx_line),
    .rx_valid (rx_valid_w),
    .rx_byte  (rx_byte_w),
    .rx_err   (rx_err_w)
  );

  // ==========================================================
  // Host request checks
  assign busy_w   = (st_r != S_IDLE);
  assign accept_w = send_req && (send_code_w == RS_OK);
  assign send_code_w =
    !module_present                            ? RS_NOMOD  :
    (loop_channel_index > CHAN_MAX)            ? RS_CHAN   :
    (preamble_count < PRE_MIN ||
     preamble_count > PRE_MAX)                 ? RS_PRE    :
    ((frame_delimiter != DLM_STX_S &&
      frame_delimiter != DLM_STX_L) ||
     frame_address_bytes[ADR_BURST_BIT])       ? RS_FRAME  :
    busy_w                                     ? RS_BUSY   :
    !module_online                             ? RS_OFFL_S : RS_OK;
  assign read_code_w =
    !module_present       ? RS_NOMOD :
    !module_online        ? RD_OFFL  :
    busy_w                ? RD_WAIT  :
    (bus_state == BS_RECV) ? RS_OK   :
    bus_state[7]          ? RD_INVAL : RD_NOREQ;
  assign rd_go_w = read_req && !busy_w && (bus_state == BS_RECV);

  // ==========================================================
  // Transmit byte selection
  assign long_w  = dlm_r[DLM_LONG_BIT];
  assign alast_w = long_w ? ADR_LAST_L : ADR_LAST_S;
  assign amask_w = long_w ? ADR_MASK_L : ADR_MASK_S;
  assign tx_st_w = (st_r >= S_PRE) && (st_r <= S_CHK);
  assign rx_st_w = (st_r >= S_RADDR) && (st_r <= S_RCHK);
  assign fire_w  = tx_st_w && !tx_busy_w && !tx_go_r &&
                   (st_r != S_DATA || fifo_vld_w);
  assign pop_w   = fire_w && (st_r == S_DATA);
  assign txb_w   = (st_r == S_PRE)  ? PRE_BYTE          :
                   (st_r == S_DLM)  ? dlm_r             :
                   (st_r == S_ADDR) ? abyte(addr_r, idx_r) :
                   (st_r == S_CMD)  ? cmd_r             :
                   (st_r == S_CNT)  ? len_r             :
                   (st_r == S_DATA) ? txb_w_fifo        : chk_r;

  // ==========================================================
  // Response evaluation at the check byte
  assign dlm_ok_w = rx_byte_w == (long_w ? DLM_ACK_L : DLM_ACK_S);
  assign gap_w    = (tmr_r >= 32'(GAP_CYCLES));
  assign eval_w   =
    rerr_r                                          ? BS_RESP   :
    (raddr_r[ADR_MASTER_BIT] != addr_r[ADR_MASTER_BIT]) ? BS_MASTER :
    raddr_r[ADR_BURST_BIT]                          ? BS_BURST  :
    (rcmd_r != cmd_r)                               ? BS_CMD    :
    ((rchk_r ^ rx_byte_w) != 8'h00)                 ? BS_CHK    :
    ((raddr_r & amask_w) != (addr_r & amask_w))     ? BS_MISM   :
    BS_RECV;
  assign nbus_w   = !module_present ? BS_NOMOD :
                    !module_online  ? BS_OFFL  : BS_IDLE;
  assign mem_we_w = (st_r == S_RBODY) && rx_valid_w && (idx_r >= RC_BYTES);

  // Response data store, data bytes only
  always_ff @(posedge clk)
  begin
    if (mem_we_w)
      mem[idx_r - RC_BYTES] <= rx_byte_w;
  end

  // ==========================================================
  // Transaction sequencer
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      st_r <= S_IDLE;
      bus_state <= BS_IDLE;
      {pre_r, dlm_r, cmd_r, len_r, idx_r, chk_r, txb_r} <= '0;
      addr_r <= '0;
      chan_sel <= '0;
      tx_go_r <= 1'b0;
      tx_enable <= 1'b0;
      tmr_r <= '0;
      {rpre_r, rdlm_r, rcmd_r, rcnt_r, rchk_r} <= '0;
      raddr_r <= '0;
      rc_r <= '0;
      rerr_r <= 1'b0;
    end
    else
    begin
      tx_go_r <= fire_w;
      tmr_r <= tmr_r + 32'h1;
      if (fire_w)
      begin
        txb_r <= txb_w;
        tmr_r <= '0;
        idx_r <= idx_r + 8'h01;
        if (st_r != S_PRE && st_r != S_CHK)
          chk_r <= chk_r ^ txb_w;
      end
      if (rx_valid_w)
        tmr_r <= '0;
      if (rx_st_w && rx_valid_w && st_r != S_RCHK)
        rchk_r <= rchk_r ^ rx_byte_w;
      if (rx_st_w && rx_valid_w && rx_err_w)
        rerr_r <= 1'b1;
      unique case (st_r)
        S_IDLE:
        begin
          if (bus_state == BS_IDLE || bus_state == BS_NOMOD ||
              bus_state == BS_OFFL || rd_go_w ||
              (read_req && bus_state[7]))
            bus_state <= nbus_w;
          if (accept_w)
          begin
            st_r <= S_PRE;
            bus_state <= BS_QUEUED;
            chan_sel <= loop_channel_index[2:0];
            pre_r <= preamble_count;
            dlm_r <= frame_delimiter;
            addr_r <= frame_address_bytes;
            cmd_r <= frame_command;
            len_r <= payload_length;
            idx_r <= '0;
            chk_r <= '0;
            tx_enable <= 1'b1;
          end
        end
        S_PRE:
          if (fire_w && idx_r == pre_r - 8'h01)
          begin
            st_r <= S_DLM;
            idx_r <= '0;
          end
        S_DLM:
          if (fire_w)
          begin
            st_r <= S_ADDR;
            idx_r <= '0;
          end
        S_ADDR:
          if (fire_w && idx_r == alast_w)
            st_r <= S_CMD;
        S_CMD:
          if (fire_w)
            st_r <= S_CNT;
        S_CNT:
          if (fire_w)
          begin
            st_r <= (len_r == 8'h00) ? S_CHK : S_DATA;
            idx_r <= '0;
          end
        S_DATA:
          if (fire_w && idx_r == len_r - 8'h01)
            st_r <= S_CHK;
          else if (!fire_w && gap_w)
          begin
            st_r <= S_IDLE; // Payload never arrived
            bus_state <= BS_IMPOSS;
            tx_enable <= 1'b0;
          end
        S_CHK:
          if (fire_w)
            st_r <= S_FLUSH;
        S_FLUSH:
          if (!tx_busy_w && !tx_go_r)
          begin
            st_r <= S_WAIT;
            bus_state <= BS_SENT;
            tx_enable <= 1'b0;
            tmr_r <= '0;
            rpre_r <= '0;
            rerr_r <= 1'b0;
          end
        S_WAIT, S_RPRE:
        begin
          if (st_r == S_WAIT)
            bus_state <= BS_WAIT;
          if (rx_valid_w && rx_byte_w == PRE_BYTE)
          begin
            st_r <= S_RPRE;
            rpre_r <= rpre_r + 8'h01;
          end
          else if (rx_valid_w && dlm_ok_w)
          begin
            st_r <= S_RADDR;
            rdlm_r <= rx_byte_w;
            rchk_r <= rx_byte_w;
            idx_r <= '0;
          end
          else if (rx_valid_w)
          begin
            st_r <= S_IDLE;
            bus_state <= BS_DLM;
          end
          else if (st_r == S_WAIT && tmr_r >= 32'(RESP_CYCLES))
          begin
            st_r <= S_IDLE;
            bus_state <= BS_TMO;
          end
          else if (st_r == S_RPRE && gap_w)
          begin
            st_r <= S_IDLE;
            bus_state <= BS_SHORT;
          end
        end
        S_RADDR:
          if (rx_valid_w)
          begin
            raddr_r[{idx_r[2:0], 3'b000} +: 8] <= rx_byte_w;
            idx_r <= idx_r + 8'h01;
            if (idx_r == alast_w)
              st_r <= S_RCMD;
          end
        S_RCMD:
          if (rx_valid_w)
          begin
            rcmd_r <= rx_byte_w;
            st_r <= S_RCNT;
          end
        S_RCNT:
          if (rx_valid_w)
          begin
            rcnt_r <= rx_byte_w;
            idx_r <= '0;
            st_r <= S_RBODY;
            if (rx_byte_w < RC_BYTES)
            begin
              st_r <= S_IDLE;
              bus_state <= BS_SHORT;
            end
          end
        S_RBODY:
          if (rx_valid_w)
          begin
            if (idx_r < RC_BYTES)
              rc_r <= {rc_r[7:0], rx_byte_w};
            idx_r <= idx_r + 8'h01;
            if (idx_r == rcnt_r - 8'h01)
              st_r <= S_RCHK;
          end
        S_RCHK:
          if (rx_valid_w)
          begin
            st_r <= S_IDLE;
            bus_state <= eval_w;
          end
      endcase
      if (rx_st_w && !rx_valid_w && gap_w)
      begin
        st_r <= S_IDLE;
        bus_state <= BS_SHORT;
      end
      if (line_fault && (tx_st_w || st_r == S_FLUSH))
      begin
        st_r <= S_IDLE;
        bus_state <= BS_TXFAIL;
        tx_enable <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Host answers and read-out stream
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      {send_done, read_done, rd_valid} <= '0;
      {send_status, read_status, rd_byte} <= '0;
      {resp_preamble_count, resp_delimiter, resp_command} <= '0;
      resp_address_bytes <= '0;
      resp_code <= '0;
      resp_payload_length <= '0;
      rd_idx_r <= '0;
      rd_left_r <= '0;
    end
    else
    begin
      send_done <= send_req;
      read_done <= read_req;
      if (send_req)
        send_status <= send_code_w;
      if (read_req)
        read_status <= read_code_w;
      rd_valid <= (rd_left_r != 8'h00);
      rd_byte <= mem[rd_idx_r];
      if (rd_left_r != 8'h00)
      begin
        rd_idx_r <= rd_idx_r + 8'h01;
        rd_left_r <= rd_left_r - 8'h01;
      end
      if (rd_go_w)
      begin
        resp_preamble_count <= rpre_r;
        resp_delimiter <= rdlm_r;
        resp_address_bytes <= raddr_r & (long_w ? '1 : 40'h00_0000_00FF);
        resp_command <= rcmd_r;
        resp_code <= rc_r;
        resp_payload_length <= rcnt_r - RC_BYTES;
        rd_idx_r <= '0;
        rd_left_r <= rcnt_r - RC_BYTES;
      end
    end
  end
endmodule

// [dv/hmfe_properties.sv]
// Port assertions for the frame engine
`timescale 1ns/100ps
module hmfe_properties
  import hmfe_pkg::*;
(
  input logic       clk,
  input logic       reset,
  input logic       module_present,
  input logic       module_online,
  input logic       send_req,
  input logic [3:0] loop_channel_index,
  input logic [7:0] preamble_count,
  input logic       read_req,
  input logic       send_done,
  input logic [7:0] send_status,
  input logic       read_done,
  input logic [7:0] read_status,
  input logic [7:0] bus_state,
  input logic       tx_enable,
  input logic       tx_line
);
  // ==========================================================
  // Request decode
  wire sr  = send_req && module_present;
  wire cok = loop_channel_index <= CHAN_MAX;
  wire pbd = preamble_count < PRE_MIN || preamble_count > PRE_MAX;
  wire rr  = read_req && module_present && module_online;
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  send_done_a: assert property (send_req |=> send_done)
    else $error("send not answered");
  read_done_a: assert property (read_req |=> read_done)
    else $error("read not answered");
  chan_reject_a: assert property (sr && !cok |=> send_status == RS_CHAN)
    else $error("bad channel accepted");
  pre_reject_a: assert property (sr && cok && pbd |=> send_status == RS_PRE)
    else $error("bad preamble accepted");
  accept_state_a: assert property (send_done && send_status == RS_OK
    |-> bus_state == BS_QUEUED && tx_enable) else $error("accept wrong");
  idle_line_a: assert property (!tx_enable |-> tx_line)
    else $error("line not idle");
  noreq_read_a: assert property (rr && bus_state == BS_IDLE
    |=> read_status == RD_NOREQ) else $error("no-request read");
  read_ok_a: assert property (rr && bus_state == BS_RECV
    |=> read_status == RS_OK && bus_state == BS_IDLE) else $error("read");
endmodule
bind hmfe_engine hmfe_properties hmfe_properties_inst (.*);

// [dv/hmfe_slave.sv]
// Field device model answering each request with a short reply while en is set
`timescale 1ns/100ps
module hmfe_slave
#(
  parameter logic [15:0] RC = 16'hA53C
)
(
  input  logic       clk,
  input  logic       tx_enable,
  input  logic       en,
  input  logic       bad_chk,
  input  logic [7:0] adr,
  input  logic [7:0] frame_command,
  output logic       rx_line
);
  logic [7:0] q[$];
  logic [7:0] c;
  initial rx_line = 1'b1;
  // One character, start bit first, each bit eight clocks
  task automatic put(input logic [7:0] b);
    logic [10:0] s;
    s = {1'b1, ~^b, b, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      @(posedge clk);
      rx_line <= s[i];
      repeat (7) @(posedge clk);
    end
  endtask
  // Reply once the request has left the line
  always @(negedge tx_enable)
    if (en)
    begin
      repeat (40) @(posedge clk);
      q = {8'h06, adr, frame_command, 8'h02, RC[15:8], RC[7:0]};
      c = {7'h00, bad_chk};
      foreach (q[i]) c ^= q[i];
      repeat (5) put(8'hFF);
      foreach (q[i]) put(q[i]);
      put(c);
    end
endmodule

// [dv/test_hmfe_engine.sv]
// Self-checking bench for the frame engine
`timescale 1ns/100ps
module test_hmfe_engine;
  import hmfe_pkg::*;
  logic        clk = 0, reset = 1, module_present = 1, module_online = 1;
  logic        line_fault = 0, send_req = 0, read_req = 0, pay_valid = 0;
  logic        en = 0, bad_chk = 0, pay_ready, tx_enable, tx_line, rx_line;
  logic [3:0]  loop_channel_index = 0;
  logic [7:0]  preamble_count = 5, frame_delimiter = 0, frame_command = 0;
  logic [7:0]  payload_length = 0, pay_data = 0, adr = 0, pr, x, b;
  logic [7:0]  send_status, read_status, bus_state, resp_command;
  logic [7:0]  resp_preamble_count, resp_delimiter, resp_payload_length;
  logic [2:0]  chan_sel;
  logic [7:0]  d[4], txq[$], exq[$];
  logic [15:0] resp_code;
  logic [39:0] frame_address_bytes, resp_address_bytes;
  int          num_errors = 0, tests_run = 0;
  assign frame_address_bytes = {32'h0, adr};
  always #5 clk = ~clk;
  hmfe_engine #(.BIT_CYCLES(8), .RESP_CYCLES(2000), .GAP_CYCLES(176))
    hmfe_engine_inst (.*, .send_done(), .read_done(), .rd_valid(),
    .rd_byte());
  hmfe_slave hmfe_slave_inst (.*);
  task automatic chk(input string n, input logic [15:0] e, s);
    tests_run++;
    if (s !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic snd(input logic [3:0] c, input logic [7:0] p, l, e);
    loop_channel_index = c;
    preamble_count = p;
    frame_delimiter = l;
    send_req = 1;
    @(posedge clk) #1;
    send_req = 0;
    @(posedge clk) #1;
    chk("send_status", e, send_status);
  endtask
  task automatic rd(input logic [7:0] e);
    read_req = 1;
    @(posedge clk) #1;
    read_req = 0;
    @(posedge clk) #1;
    chk("read_status", e, read_status);
  endtask
  task automatic wt(input logic [7:0] s);
    for (int i = 0; i < 5000 && bus_state !== s; i++)
      @(posedge clk) #1;
    chk("bus_state", s, bus_state);
  endtask
  // Collect characters the engine puts on the line
  always @(negedge tx_line)
    if (tx_enable)
    begin
      repeat (12) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
        b[i] = tx_line;
        repeat (8) @(posedge clk);
      end
      txq.push_back(b);
    end
  // Main sequence
  initial
  begin
    void'($urandom(89));
    repeat (10) @(posedge clk);
    #1 reset = 0;
    chk("bus_state", BS_IDLE, bus_state);
    rd(RD_NOREQ);
    snd(4'h8, 8'h05, 8'h02, RS_CHAN);
    snd(4'h0, 8'h04, 8'h02, RS_PRE);
    snd(4'h0, 8'h15, 8'h02, RS_PRE);
    snd(4'h0, 8'h05, 8'h06, RS_FRAME);
    adr = 8'h80 | 8'($urandom % 64);
    frame_command = 8'($urandom);
    payload_length = 8'h04;
    pay_valid = 1;
    for (int i = 0; i < 4; i++)
    begin
      d[i] = 8'($urandom);
      pay_data = d[i];
      @(posedge clk) #1;
    end
    pay_valid = 0;
    chk("pay_ready", 0, pay_ready);
    en = 1;
    pr = 8'h05 + 8'($urandom % 16);
    snd(4'h3, pr, 8'h02, RS_OK);
    chk("chan_sel", 3'h3, chan_sel);
    snd(4'h3, pr, 8'h02, RS_BUSY);
    wt(BS_WAIT);
    exq = {8'h02, adr, frame_command, 8'h04, d[0], d[1], d[2], d[3]};
    x = 0;
    foreach (exq[i]) x ^= exq[i];
    exq.push_back(x);
    for (int i = 0; i < pr; i++) exq.push_front(8'hFF);
    chk("tx_count", 16'(exq.size()), 16'(txq.size()));
    foreach (exq[i]) chk("tx_byte", exq[i], txq[i]);
    wt(BS_RECV);
    rd(RS_OK);
    chk("resp_command", frame_command, resp_command);
    chk("resp_code", 16'hA53C, resp_code);
    chk("resp_preamble", 8'h05, resp_preamble_count);
    chk("resp_delimiter", DLM_ACK_S, resp_delimiter);
    chk("resp_address", 16'(adr), resp_address_bytes[15:0]);
    chk("resp_length", 8'h00, resp_payload_length);
    chk("bus_state", BS_IDLE, bus_state);
    bad_chk = 1;
    payload_length = 8'h00;
    snd(4'h7, 8'h14, 8'h02, RS_OK);
    wt(BS_CHK);
    rd(RD_INVAL);
    en = 0;
    snd(4'h0, 8'h05, 8'h02, RS_OK);
    wt(BS_TMO);
    rd(RD_INVAL);
    module_present = 0;
    repeat (2) @(posedge clk) #1;
    chk("bus_state", BS_NOMOD, bus_state);
    tally_and_finish;
  end
  // Watchdog
  initial
  begin
    #300_000;
    num_errors++;
    tally_and_finish;
  end
endmodule
